// [rtl/rcwd_defines.vh]
// Purpose: shared constants of the reset cause and watchdog block
// Assumes: byte addresses on a 32-bit AXI4-Lite register bus
// Notes: definitions only
`ifndef RCWD_DEFINES_VH
`define RCWD_DEFINES_VH
`define RCWD_ADDR_CAUSE 4'h0
`define RCWD_ADDR_WDCTL 4'h4
`define RCWD_ADDR_CFG 4'h8
`define RCWD_ADDR_STAT 4'hC
`define RCWD_BIT_SCAN 4
`define RCWD_BIT_WDOG 3
`define RCWD_BIT_BROWN 2
`define RCWD_BIT_EXT 1
`define RCWD_BIT_POR 0
`define RCWD_BIT_TOE 4
`define RCWD_BIT_WDE 3
`define RCWD_TOE_CYCLES 3'h4
`define RCWD_WD_BASE_LOG2 14
`define RCWD_CFG_RESET 8'h00
`define RCWD_RESP_OKAY 2'h0
`define RCWD_RESP_SLVERR 2'h2
`endif

// [rtl/rcwd_filter.v]
// Purpose: qualify a reset request that must persist for a minimum time
// Assumes: input already synchronous to clk_sys
// Notes: output rises only after the input has stood CYCLES clocks
`timescale 1ns/1ns
module rcwd_filter #(
   parameter CYCLES = 4,
   parameter CW = 8
) (
   clk_sys,
   rst,
   rawIn,
   qualOut
);
   input wire clk_sys;
   input wire rst;
   input wire rawIn;
   output reg qualOut;
   // Last count before the qualified level; sized to the counter
   localparam [CW-1:0] LAST = CYCLES - 1;
   reg [CW-1:0] cnt_reg;

   // Count while held; any gap restarts the count
   always @(posedge clk_sys) begin
      if (rst || !rawIn) begin
         cnt_reg <= {CW{1'b0}};
         qualOut <= 1'b0;
      end else if (cnt_reg >= LAST) begin
         qualOut <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end
endmodule

// [rtl/rcwd_watchdog.v]
// Purpose: watchdog counter with selectable time-out
// Assumes: tick marks one period of the 1 MHz watchdog oscillator
// Notes: timeout is a one-cycle pulse on clk_sys
`timescale 1ns/1ns
module rcwd_watchdog #(
   parameter BASE_LOG2 = 14
) (
   clk_sys,
   rst,
   enable,
   restart,
   tick,
   prescale,
   timeout
);
   input wire clk_sys;
   input wire rst;
   input wire enable;
   input wire restart;
   input wire tick;
   input wire [2:0] prescale;
   output reg timeout;
   localparam W = BASE_LOG2 + 8;
   reg [W-1:0] cnt_reg;
   wire [W-1:0] limit;

   assign limit = ({{(W-1){1'b0}}, 1'b1} << (BASE_LOG2 + prescale)) - 1'b1;

   always @(posedge clk_sys) begin
      timeout <= 1'b0;
      if (rst || !enable || restart) begin
         cnt_reg <= {W{1'b0}};
      end else if (tick) begin
         if (cnt_reg >= limit) begin
            cnt_reg <= {W{1'b0}};
            timeout <= 1'b1;
         end else begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end
endmodule

// [rtl/rcwd_top.v]
// Purpose: reset source combining, start-up delay, cause flags, watchdog
// Assumes: detector levels and pin synchronous to clk_sys
// Notes: registers reached over AXI4-Lite, one word each
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "rcwd_defines.vh"
module rcwd_top #(
   parameter DELAY_W = 20,
   parameter PIN_MIN_CYCLES = 4,
   parameter BROWN_MIN_CYCLES = 8,
   parameter WD_BASE_LOG2 = `RCWD_WD_BASE_LOG2
) (
   clk_sys,
   rst,
   supplyLow,
   resetPinN,
   brownLow,
   brownoutDetectorEnableFuse,
   clockSelectFuses,
   scanResetReg,
   watchdogTick,
   watchdogRestartInstruction,
   converterEnable,
   comparatorBandgapSelect,
   coreReset,
   bandgapEnable,
   s_axi_awaddr,
   s_axi_awvalid,
   s_axi_awready,
   s_axi_wdata,
   s_axi_wstrb,
   s_axi_wvalid,
   s_axi_wready,
   s_axi_bresp,
   s_axi_bvalid,
   s_axi_bready,
   s_axi_araddr,
   s_axi_arvalid,
   s_axi_arready,
   s_axi_rdata,
   s_axi_rresp,
   s_axi_rvalid,
   s_axi_rready
);
   input wire clk_sys;
   input wire rst;
   input wire supplyLow;
   input wire resetPinN;
   input wire brownLow;
   input wire brownoutDetectorEnableFuse;
   input wire [3:0] clockSelectFuses;
   input wire scanResetReg;
   input wire watchdogTick;
   input wire watchdogRestartInstruction;
   input wire converterEnable;
   input wire comparatorBandgapSelect;
   output reg coreReset;
   output reg bandgapEnable;
   input wire [3:0] s_axi_awaddr;
   input wire s_axi_awvalid;
   output reg s_axi_awready;
   input wire [31:0] s_axi_wdata;
   input wire [3:0] s_axi_wstrb;
   input wire s_axi_wvalid;
   output reg s_axi_wready;
   output reg [1:0] s_axi_bresp;
   output reg s_axi_bvalid;
   input wire s_axi_bready;
   input wire [3:0] s_axi_araddr;
   input wire s_axi_arvalid;
   output reg s_axi_arready;
   output reg [31:0] s_axi_rdata;
   output reg [1:0] s_axi_rresp;
   output reg s_axi_rvalid;
   input wire s_axi_rready;

   localparam ST_RUN = 3'b001;
   localparam ST_HOLD = 3'b010;
   localparam ST_DELAY = 3'b100;

   reg [2:0] state_reg;
   reg [DELAY_W-1:0] delay_reg;
   reg [4:0] cause_reg;
   reg [4:0] cause_next;
   reg toe_reg;
   reg wde_reg;
   reg [2:0] presc_reg;
   reg [2:0] toeCnt_reg;
   reg [3:0] awaddr_reg;
   reg awHave_reg;
   reg [31:0] wdata_reg;
   reg [3:0] wstrb_reg;
   reg wHave_reg;
   reg [DELAY_W-1:0] delayLimit;
   wire pinQual;
   wire brownQual;
   wire wdTimeout;
   wire brownActive;
   wire anySource;
   wire wrFire;
   wire wrLow;

   // Pin low must persist to count
   rcwd_filter #(.CYCLES(PIN_MIN_CYCLES), .CW(8)) uPin (
      .clk_sys(clk_sys),
      .rst(rst),
      .rawIn(!resetPinN),
      .qualOut(pinQual)
   );

   rcwd_filter #(.CYCLES(BROWN_MIN_CYCLES), .CW(8)) uBrown (
      .clk_sys(clk_sys),
      .rst(rst),
      .rawIn(brownLow),
      .qualOut(brownQual)
   );

   // Counts ticks of the watchdog oscillator
   rcwd_watchdog #(.BASE_LOG2(WD_BASE_LOG2)) uWdog (
      .clk_sys(clk_sys),
      .rst(rst || coreReset),
      .enable(wde_reg),
      .restart(watchdogRestartInstruction),
      .tick(watchdogTick),
      .prescale(presc_reg),
      .timeout(wdTimeout)
   );

   assign brownActive = brownoutDetectorEnableFuse && brownQual;
   assign anySource = supplyLow || pinQual || brownActive || scanResetReg;

   always @* begin
      delayLimit = {{(DELAY_W-1){1'b0}}, 1'b1} << clockSelectFuses;
   end

   // Reset sequencer; source level is ORed straight into the output
   // path, so assertion costs one flop of latency and no more
   always @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= ST_HOLD;
         delay_reg <= {DELAY_W{1'b0}};
         coreReset <= 1'b1;
      end else begin
         case (state_reg)
            ST_RUN: begin
               if (anySource) begin
                  state_reg <= ST_HOLD;
                  coreReset <= 1'b1;
               end else if (wdTimeout) begin
                  state_reg <= ST_DELAY;
                  delay_reg <= {DELAY_W{1'b0}};
                  coreReset <= 1'b1;
               end
            end
            ST_HOLD: begin
               coreReset <= 1'b1;
               delay_reg <= {DELAY_W{1'b0}};
               if (!anySource) begin
                  state_reg <= ST_DELAY;
               end
            end
            ST_DELAY: begin
               coreReset <= 1'b1;
               if (anySource) begin
                  state_reg <= ST_HOLD;
                  delay_reg <= {DELAY_W{1'b0}};
               end else if (delay_reg >= delayLimit) begin
                  state_reg <= ST_RUN;
                  coreReset <= 1'b0;
               end else begin
                  delay_reg <= delay_reg + 1'b1;
               end
            end
            default: begin
               state_reg <= ST_HOLD;
               coreReset <= 1'b1;
            end
         endcase
      end
   end

   // AXI write channels, taken in either order
   assign wrFire = awHave_reg && wHave_reg && !s_axi_bvalid;
   assign wrLow = wstrb_reg[0];
   always @(posedge clk_sys) begin
      if (rst) begin
         awHave_reg <= 1'b0;
         wHave_reg <= 1'b0;
         awaddr_reg <= 4'h0;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RCWD_RESP_OKAY;
      end else begin
         s_axi_awready <= !awHave_reg && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !wHave_reg && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awready && s_axi_awvalid) begin
            awHave_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wready && s_axi_wvalid) begin
            wHave_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (wrFire) begin
            awHave_reg <= 1'b0;
            wHave_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awaddr_reg[1:0] != 2'h0 || awaddr_reg == `RCWD_ADDR_CFG) begin
               s_axi_bresp <= `RCWD_RESP_SLVERR;
            end else begin
               s_axi_bresp <= `RCWD_RESP_OKAY;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Cause flags: hardware set wins over a software zero
   always @* begin
      cause_next = cause_reg;
      if (wrFire && wrLow && awaddr_reg == `RCWD_ADDR_CAUSE) begin
         cause_next = cause_reg & wdata_reg[4:0];
      end
      if (scanResetReg) cause_next[`RCWD_BIT_SCAN] = 1'b1;
      if (wdTimeout && state_reg == ST_RUN) cause_next[`RCWD_BIT_WDOG] = 1'b1;
      if (brownActive) cause_next[`RCWD_BIT_BROWN] = 1'b1;
      if (pinQual) cause_next[`RCWD_BIT_EXT] = 1'b1;
      if (supplyLow) begin
         cause_next[4:1] = 4'h0;
         cause_next[`RCWD_BIT_POR] = 1'b1;
      end
   end

   // Flags survive rst so software can read the cause after it
   always @(posedge clk_sys) begin
      cause_reg <= cause_next;
   end

   // Watchdog control register with protected disable
   always @(posedge clk_sys) begin
      if (rst || coreReset) begin
         toe_reg <= 1'b0;
         wde_reg <= 1'b0;
         presc_reg <= 3'h0;
         toeCnt_reg <= 3'h0;
      end else begin
         // Turn-off enable expires after four cycles
         if (toe_reg) begin
            toeCnt_reg <= toeCnt_reg + 1'b1;
            if (toeCnt_reg == `RCWD_TOE_CYCLES - 1'b1) toe_reg <= 1'b0;
         end
         if (wrFire && wrLow && awaddr_reg == `RCWD_ADDR_WDCTL) begin
            presc_reg <= wdata_reg[2:0];
            // Zero only honoured with turn-off enable
            if (wdata_reg[`RCWD_BIT_WDE]) begin
               wde_reg <= 1'b1;
            end else if (toe_reg) begin
               wde_reg <= 1'b0;
            end
            if (wdata_reg[`RCWD_BIT_TOE]) begin
               toe_reg <= 1'b1;
               toeCnt_reg <= 3'h0;
            end
         end
      end
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         bandgapEnable <= 1'b0;
      end else begin
         bandgapEnable <= brownoutDetectorEnableFuse || comparatorBandgapSelect ||
            converterEnable;
      end
   end

   // AXI read channel
   always @(posedge clk_sys) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `RCWD_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arready && s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RCWD_RESP_OKAY;
            case (s_axi_araddr)
               `RCWD_ADDR_CAUSE: s_axi_rdata <= {27'h0, cause_reg};
               `RCWD_ADDR_WDCTL: s_axi_rdata <= {27'h0, toe_reg, wde_reg, presc_reg};
               `RCWD_ADDR_STAT: s_axi_rdata <= {29'h0, bandgapEnable, wde_reg, coreReset};
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= `RCWD_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// [verif/rcwd_partner.sv]
// Purpose: supply monitors, reset pin and watchdog oscillator
// Assumes: levels change just after clk_sys edges
// Notes: one oscillator tick every 125 system clocks
`timescale 1ns/1ns
module rcwd_partner (
   output reg supplyLow,
   output reg resetPinN,
   output reg brownLow,
   output reg watchdogTick,
   input wire clk_sys
);
   reg [6:0] divCnt;
   // Power comes up with the supply still below threshold
   initial begin
      supplyLow = 1'b1;
      resetPinN = 1'b1;
      brownLow = 1'b0;
      watchdogTick = 1'b0;
      divCnt = 7'h00;
   end
   always @(posedge clk_sys) begin
      divCnt <= (divCnt == 7'h7C) ? 7'h00 : divCnt + 7'h01;
      watchdogTick <= (divCnt == 7'h7C);
   end
   // Drop one monitor for n cycles: 0 supply, 1 pin, 2 brown-out
   task dip(input integer src, input integer n);
      begin
         @(posedge clk_sys);
         supplyLow <= (src == 0);
         resetPinN <= (src != 1);
         brownLow <= (src == 2);
         repeat (n) @(posedge clk_sys);
         supplyLow <= 1'b0;
         resetPinN <= 1'b1;
         brownLow <= 1'b0;
      end
   endtask
endmodule

// [verif/rcwd_top_asserts.sv]
// Purpose: port-level checks of the reset cause and watchdog block
// Assumes: single clock domain, bound to the top module
// Notes: run-length counters stand in for long repetitions
`timescale 1ns/1ns
module rcwd_top_asserts #(
   parameter PIN_MIN_CYCLES = 4,
   parameter BROWN_MIN_CYCLES = 8
) (
   input wire clk_sys,
   input wire rst,
   input wire supplyLow,
   input wire resetPinN,
   input wire brownLow,
   input wire brownoutDetectorEnableFuse,
   input wire [3:0] clockSelectFuses,
   input wire scanResetReg,
   input wire converterEnable,
   input wire comparatorBandgapSelect,
   input wire coreReset,
   input wire bandgapEnable,
   input wire s_axi_awvalid,
   input wire s_axi_wvalid,
   input wire s_axi_bvalid,
   input wire s_axi_arvalid,
   input wire s_axi_rvalid
);
   reg [7:0] pinCnt;
   reg [7:0] brnCnt;
   reg [15:0] quietCnt;
   // Run lengths; quiet count saturates so long idle never wraps
   always @(posedge clk_sys) begin
      if (rst) begin
         pinCnt <= 8'h00;
         brnCnt <= 8'h00;
         quietCnt <= 16'h0000;
      end else begin
         pinCnt <= resetPinN ? 8'h00 : pinCnt + 8'h01;
         brnCnt <= (brownLow & brownoutDetectorEnableFuse) ? brnCnt + 8'h01 : 8'h00;
         quietCnt <= (supplyLow | scanResetReg | !resetPinN | brownLow) ? 16'h0000 :
            quietCnt + {15'h0000, ~&quietCnt};
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   a_supply_reset: assert property (supplyLow |=> coreReset)
      else $error("supply low without core reset");
   a_scan_hold: assert property (scanResetReg |=> coreReset)
      else $error("scan request without core reset");
   a_pin_reset: assert property (pinCnt == PIN_MIN_CYCLES |-> ##[0:3] coreReset)
      else $error("long pin pulse ignored");
   a_brown_reset: assert property (brnCnt == BROWN_MIN_CYCLES |-> ##[0:3] coreReset)
      else $error("long brown-out ignored");
   a_release_delay: assert property ($fell(coreReset) |->
      quietCnt >= (16'h0001 << clockSelectFuses)) else $error("core released too early");
   a_bandgap_or: assert property (1'b1 |=> bandgapEnable ==
      $past(brownoutDetectorEnableFuse | comparatorBandgapSelect | converterEnable))
      else $error("bandgap enable wrong");
   a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
      |-> ##[1:4] s_axi_bvalid) else $error("write not answered");
   a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |-> ##[1:4] s_axi_rvalid)
      else $error("read not answered");
endmodule

// [verif/rcwd_top_tb.sv]
// Purpose: self-checking bench for the reset cause and watchdog block
// Assumes: partner drives supply, pin, brown-out and oscillator tick
// Notes: watchdog base shortened to 4 ticks to keep the run brief
`timescale 1ns/1ns
`include "rcwd_defines.vh"
module rcwd_top_tb;
   localparam [3:0] CAUSE = `RCWD_ADDR_CAUSE;
   localparam [3:0] WDCTL = `RCWD_ADDR_WDCTL;
   localparam [3:0] STAT = `RCWD_ADDR_STAT;
   localparam TICK = 125;
   integer seed = 49, n_fail = 0, checked = 0, cyc = 0, n, i, p;
   reg clk_sys, rst = 1'b1, fuse = 1'b1, cmpSel = 1'b0, convEn = 1'b0;
   reg scanReg = 1'b0, restart = 1'b0, awValid = 1'b0, wValid = 1'b0, arValid = 1'b0;
   reg bReady = 1'b0, rReady = 1'b0;
   reg [3:0] awAddr = 4'h0, arAddr = 4'h0, wStrb = 4'h0;
   reg [31:0] wData = 32'h0, rv;
   reg [1:0] resp;
   wire supplyLow, resetPinN, brownLow, tick, coreReset, bandgapEnable;
   wire awReady, wReady, bValid, arReady, rValid;
   wire [1:0] bResp, rResp;
   wire [31:0] rData;
   rcwd_top #(.WD_BASE_LOG2(2)) u_rcwd_top (.clk_sys(clk_sys), .rst(rst),
      .supplyLow(supplyLow), .resetPinN(resetPinN), .brownLow(brownLow),
      .brownoutDetectorEnableFuse(fuse), .clockSelectFuses(4'h2), .scanResetReg(scanReg),
      .watchdogTick(tick), .watchdogRestartInstruction(restart), .converterEnable(convEn),
      .comparatorBandgapSelect(cmpSel), .coreReset(coreReset), .bandgapEnable(bandgapEnable),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
      .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));
   rcwd_partner u_rcwd_partner (.clk_sys(clk_sys), .supplyLow(supplyLow),
      .resetPinN(resetPinN), .brownLow(brownLow), .watchdogTick(tick));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // Hang guard, well above the expected run length
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         results;
      end
   end
   task results;
      begin
         $display("checked %0d n_fail %0d", checked, n_fail);
         if (n_fail == 0 && checked > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   task check(input [31:0] seen, input [31:0] exp, input string nm);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // Write: valids held until each is taken, ready left high
   task wr(input [3:0] a, input [31:0] d);
      begin
         awAddr <= a;
         wData <= d;
         wStrb <= 4'hF;
         awValid <= 1'b1;
         wValid <= 1'b1;
         bReady <= 1'b1;
         @(posedge clk_sys);
         while (awValid | wValid | !bValid) begin
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
            @(posedge clk_sys);
         end
         resp = bResp;
      end
   endtask
   task rd(input [3:0] a);
      begin
         arAddr <= a;
         arValid <= 1'b1;
         rReady <= 1'b1;
         @(posedge clk_sys);
         while (arValid | !rValid) begin
            if (arReady) arValid <= 1'b0;
            @(posedge clk_sys);
         end
         rv = rData;
         resp = rResp;
      end
   endtask
   task rchk(input [3:0] a, input [31:0] e, input string nm);
      begin
         rd(a);
         check(rv, e, nm);
      end
   endtask
   task run;
      while (coreReset !== 1'b0) @(posedge clk_sys);
   endtask
   function [31:0] wdCyc(input integer ps);
      wdCyc = (32'h4 << ps) * TICK;
   endfunction
   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      u_rcwd_partner.dip(0, 5);
      run;
      rchk(CAUSE, 32'h1, "cause");
      rchk(WDCTL, 32'h0, "wdctl");
      u_rcwd_partner.dip(1, 2);
      repeat (6) @(posedge clk_sys);
      check(coreReset, 32'h0, "reset");
      u_rcwd_partner.dip(1, 10);
      run;
      rchk(CAUSE, 32'h3, "cause");
      u_rcwd_partner.dip(2, 4);
      repeat (6) @(posedge clk_sys);
      check(coreReset, 32'h0, "reset");
      u_rcwd_partner.dip(2, 14);
      run;
      rchk(CAUSE, 32'h7, "cause");
      rv = $random(seed);
      wr(CAUSE, rv);
      rchk(CAUSE, rv & 32'h7, "cause");
      wr(CAUSE, 32'h0);
      $display("end of pin and brown-out test");
      scanReg <= 1'b1;
      repeat (30) @(posedge clk_sys);
      check(coreReset, 32'h1, "reset");
      scanReg <= 1'b0;
      run;
      rchk(CAUSE, 32'h10, "cause");
      u_rcwd_partner.dip(0, 3);
      run;
      rchk(CAUSE, 32'h1, "cause");
      wr(CAUSE, 32'h0);
      rchk(CAUSE, 32'h0, "cause");
      wr(`RCWD_ADDR_CFG, 32'h0);
      check(resp, `RCWD_RESP_SLVERR, "bresp");
      rchk(`RCWD_ADDR_CFG, 32'h0, "rdata");
      check(resp, `RCWD_RESP_SLVERR, "rresp");
      wr(WDCTL, 32'hE0);
      rchk(WDCTL, 32'h0, "wdctl");
      $display("end of scan and map test");
      wr(WDCTL, 32'h8);
      wr(WDCTL, 32'h0);
      rchk(WDCTL, 32'h8, "wdctl");
      wr(WDCTL, 32'h18);
      repeat (6) @(posedge clk_sys);
      rchk(WDCTL, 32'h8, "wdctl");
      for (i = 0; i < 8; i = i + 1) begin
         repeat (200) @(posedge clk_sys);
         restart <= 1'b1;
         @(posedge clk_sys);
         restart <= 1'b0;
      end
      check(coreReset, 32'h0, "reset");
      wr(WDCTL, 32'h18);
      wr(WDCTL, 32'h0);
      rchk(WDCTL, 32'h0, "wdctl");
      // Prescale codes in a seeded order; tick phase allows one tick of slack
      p = $unsigned($random(seed)) % 3;
      for (i = 0; i < 3; i = i + 1) begin
         p = (p + 1) % 3;
         wr(WDCTL, 32'h8 | p);
         n = 0;
         while (coreReset !== 1'b1) begin
            @(posedge clk_sys);
            n = n + 1;
         end
         check(n > wdCyc(p) - TICK && n < wdCyc(p) + 9, 32'h1, "period");
         run;
         rchk(CAUSE, 32'h8, "cause");
         rchk(WDCTL, 32'h0, "wdctl");
         wr(CAUSE, 32'h0);
      end
      $display("end of watchdog test");
      for (i = 0; i < 8; i = i + 1) begin
         {fuse, cmpSel, convEn} <= i[2:0];
         repeat (3) @(posedge clk_sys);
         rchk(STAT, {29'h0, |i[2:0], 2'b00}, "status");
      end
      $display("end of bandgap test");
      results;
   end
endmodule
bind rcwd_top rcwd_top_asserts #(.PIN_MIN_CYCLES(PIN_MIN_CYCLES),
   .BROWN_MIN_CYCLES(BROWN_MIN_CYCLES)) u_asserts (.clk_sys, .rst, .supplyLow,
   .resetPinN, .brownLow, .brownoutDetectorEnableFuse, .clockSelectFuses, .scanResetReg,
   .converterEnable, .comparatorBandgapSelect, .coreReset, .bandgapEnable,
   .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid, .s_axi_arvalid, .s_axi_rvalid);
